// ### logic/cct_defines.svh
// register map, field positions, reset values and timing constants
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

// register offsets
`define CCT_OFS_SYS_CTRL    8'h37
`define CCT_OFS_THERM_READ  8'h40
`define CCT_OFS_THERM_MEAS  8'h58
`define CCT_OFS_DERATE      8'h61

// reset values
`define CCT_RST_SYS_CTRL    8'h40
`define CCT_RST_THERM_READ  8'h02
`define CCT_RST_THERM_MEAS  8'h00
`define CCT_RST_DERATE      8'h34

// system control fields
`define CCT_SETPOINT_HI     7
`define CCT_SETPOINT_LO     5
`define CCT_PG_LEVEL_BIT    4
`define CCT_WD_EN_BIT       1
`define CCT_CHG_INHIBIT_BIT 0

// thermistor fields
`define CCT_POLL_MODE_BIT   7
`define CCT_TRIGGER_BIT     5
`define CCT_MEAS_EN_BIT     2

// derating fields
`define CCT_VDROP_HI        6
`define CCT_VDROP_LO        4
`define CCT_ISCALE_HI       2
`define CCT_ISCALE_LO       0

// derating arithmetic
`define CCT_VDROP_STEP_MV   9'h032
`define CCT_SCALE_FULL      4'h8

// power-good pin function: code 1x is general-purpose output
`define CCT_PG_FN_GPO_BIT   1

// bits in one i2c byte
`define CCT_BITS_PER_BYTE   4'h8

// i2c target address (arbitrary value)
`define CCT_I2C_ADDR        7'h6A

// timing
`define CCT_CLK_HZ          20000000
`define CCT_WD_TIME_S       14
`define CCT_POLL_TIME_S     1
`define CCT_WD_CYCLES       (`CCT_WD_TIME_S * `CCT_CLK_HZ)
`define CCT_POLL_CYCLES     (`CCT_POLL_TIME_S * `CCT_CLK_HZ)

`endif

// ### logic/cct_pkg.sv
// types shared by the charger control register design
package cct_pkg;
  typedef enum logic [3:0] {
    CCT_I2C_IDLE,
    CCT_I2C_ADDR,
    CCT_I2C_ADDR_ACK,
    CCT_I2C_PTR,
    CCT_I2C_PTR_ACK,
    CCT_I2C_WDATA,
    CCT_I2C_WDATA_ACK,
    CCT_I2C_RDATA,
    CCT_I2C_RDATA_ACK
  } cct_i2c_state_t;
endpackage

// ### logic/cct_i2c_target.sv
// i2c target: address match, register pointer, byte writes and reads
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_i2c_target (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic [7:0]      ptr,
  input  wire logic [7:0] rd_data,
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  output logic            xact_done
);
  logic                   scl_m_r, scl_s_r, scl_d_r;
  logic                   sda_m_r, sda_s_r, sda_d_r;
  logic                   scl_rise, scl_fall, start_c, stop_c;
  cct_pkg::cct_i2c_state_t state_r;
  logic [7:0]             shift_r;
  logic [3:0]             bit_r;
  logic                   rw_r, addressed_r, mack_r;

  // two-flop synchronisers, then one delay stage for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // bus events
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // protocol engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= cct_pkg::CCT_I2C_IDLE;
      shift_r     <= 8'h00;
      bit_r       <= 4'h0;
      rw_r        <= 1'b0;
      addressed_r <= 1'b0;
      mack_r      <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe      <= 1'b0;
      ptr         <= 8'h00;
      wr_stb      <= 1'b0;
      wr_data     <= 8'h00;
      xact_done   <= 1'b0;
    end else begin
      sda_o     <= 1'b0; // open drain: only ever pulls low
      wr_stb    <= 1'b0;
      xact_done <= 1'b0;
      if (stop_c) begin
        state_r     <= cct_pkg::CCT_I2C_IDLE;
        sda_oe      <= 1'b0;
        xact_done   <= addressed_r; // end of a transaction for us
        addressed_r <= 1'b0;
      end else if (start_c) begin
        state_r <= cct_pkg::CCT_I2C_ADDR;
        bit_r   <= 4'h0;
        sda_oe  <= 1'b0;
      end else begin
        unique case (state_r)
          cct_pkg::CCT_I2C_IDLE: begin
          end
          cct_pkg::CCT_I2C_ADDR, cct_pkg::CCT_I2C_PTR,
          cct_pkg::CCT_I2C_WDATA: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s_r};
              bit_r   <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == `CCT_BITS_PER_BYTE) begin
              bit_r <= 4'h0;
              if (state_r == cct_pkg::CCT_I2C_ADDR) begin
                if (shift_r[7:1] == `CCT_I2C_ADDR) begin
                  rw_r        <= shift_r[0];
                  addressed_r <= 1'b1;
                  sda_oe      <= 1'b1;
                  state_r     <= cct_pkg::CCT_I2C_ADDR_ACK;
                end else begin
                  state_r <= cct_pkg::CCT_I2C_IDLE;
                end
              end else if (state_r == cct_pkg::CCT_I2C_PTR) begin
                sda_oe  <= 1'b1;
                state_r <= cct_pkg::CCT_I2C_PTR_ACK;
              end else begin
                sda_oe  <= 1'b1;
                wr_stb  <= 1'b1;
                wr_data <= shift_r;
                state_r <= cct_pkg::CCT_I2C_WDATA_ACK;
              end
            end
          end
          cct_pkg::CCT_I2C_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                shift_r <= rd_data;
                sda_oe  <= ~rd_data[7];
                state_r <= cct_pkg::CCT_I2C_RDATA;
              end else begin
                sda_oe  <= 1'b0;
                state_r <= cct_pkg::CCT_I2C_PTR;
              end
            end
          end
          cct_pkg::CCT_I2C_PTR_ACK: begin
            if (scl_fall) begin
              ptr     <= shift_r;
              sda_oe  <= 1'b0;
              state_r <= cct_pkg::CCT_I2C_WDATA;
            end
          end
          cct_pkg::CCT_I2C_WDATA_ACK: begin
            if (scl_fall) begin
              ptr     <= ptr + 8'h01;
              sda_oe  <= 1'b0;
              state_r <= cct_pkg::CCT_I2C_WDATA;
            end
          end
          cct_pkg::CCT_I2C_RDATA: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_r == `CCT_BITS_PER_BYTE) begin
                bit_r   <= 4'h0;
                sda_oe  <= 1'b0;
                ptr     <= ptr + 8'h01; // next byte ready before ack ends
                state_r <= cct_pkg::CCT_I2C_RDATA_ACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe  <= ~shift_r[6];
              end
            end
          end
          cct_pkg::CCT_I2C_RDATA_ACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s_r;
            end else if (scl_fall) begin
              if (mack_r) begin
                shift_r <= rd_data;
                sda_oe  <= ~rd_data[7];
                state_r <= cct_pkg::CCT_I2C_RDATA;
              end else begin
                state_r <= cct_pkg::CCT_I2C_IDLE;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ### logic/cct_regs.sv
// charger system control and thermistor register bank with watchdog
//
// Notes on behaviour
// RULE1: bits 7-5 pick system rail target; reset code 010.
// RULE2: bit 4 sets power-good pin level in output mode; 0 pulls low.
// RULE3: watchdog on: hardware reset if no i2c transaction 14 s after supply.
// RULE4: charging allowed only with inhibit bit 0 and enable pin low.
// RULE5: on battery alone, bit 7 picks manual checks or one per second.
// RULE6: writing 1 to bit 5 starts one check; cleared when it finishes.
// RULE7: bit 2 enables thermistor fault measurement; other bits reserved.
// RULE8: derating register resets to 0x34 with two 3-bit fields.
// RULE9: when warm, regulation target drops 50 mV per code step.
// RULE10: when derating, current scales by (8 - code)/8; code 0 no cut.
// RULE11: pin follows the level bit only when its function code is 1x.
// RULE12: hardware reset powers down rails and restores register defaults.
// RULE13: watchdog restarts at supply arrival, stops after first transaction.
// RULE14: host updates by read-modify-write, keeping reserved bits.
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_regs #(
  parameter int unsigned WD_CYCLES   = `CCT_WD_CYCLES,
  parameter int unsigned POLL_CYCLES = `CCT_POLL_CYCLES
) (
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  input  wire logic       INPUT_SUPPLY_PRESENT,
  input  wire logic       CHARGE_EN_N,
  input  wire logic [1:0] PG_PIN_FUNCTION,
  input  wire logic       PG_ALT_PULL_LOW,
  input  wire logic       BATTERY_WARM,
  input  wire logic       DERATE_ACTIVE,
  input  wire logic       THERM_CHECK_DONE,
  output logic            PG_N_O,
  output logic            PG_N_OE,
  output logic [2:0]      SYS_RAIL_SETPOINT,
  output logic            CHARGE_ALLOW,
  output logic            THERM_MEASURE_EN,
  output logic            THERM_CHECK_REQ,
  output logic [8:0]      BAT_REG_DROP_MV,
  output logic [3:0]      CHG_SCALE_EIGHTHS,
  output logic            HW_RESET
);
  logic        rst_m_r, rst_n_r;
  logic        sup_m_r, sup_s_r, sup_d_r;
  logic        ce_m_r, ce_s_r;
  logic [7:0]  ptr, wr_data, rd_data;
  logic        wr_stb, xact_done;
  logic [7:0]  sys_ctrl_r, therm_read_r, therm_meas_r, derate_r;
  logic [31:0] wd_cnt_r, poll_cnt_r;
  logic        wd_armed_r, check_busy_r, poll_due;

  // read decode for the bus; the write path uses its own decode
  function automatic logic [7:0] reg_read(
    input logic [7:0] a,
    input logic [7:0] s, t, m, d
  );
    case (a)
      `CCT_OFS_SYS_CTRL:   reg_read = s;
      `CCT_OFS_THERM_READ: reg_read = t;
      `CCT_OFS_THERM_MEAS: reg_read = m;
      `CCT_OFS_DERATE:     reg_read = d;
      default:             reg_read = 8'h00; // unmapped reads as zero
    endcase
  endfunction

  // write address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // pin synchronisers
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sup_m_r <= 1'b0;
      sup_s_r <= 1'b0;
      sup_d_r <= 1'b0;
      ce_m_r  <= 1'b1;
      ce_s_r  <= 1'b1;
    end else begin
      sup_m_r <= INPUT_SUPPLY_PRESENT;
      sup_s_r <= sup_m_r;
      sup_d_r <= sup_s_r;
      ce_m_r  <= CHARGE_EN_N;
      ce_s_r  <= ce_m_r;
    end
  end

  cct_i2c_target i_cct_i2c_target (
    .clk       (CLK),
    .rst_n     (rst_n_r),
    .scl       (SCL),
    .sda_i     (SDA_I),
    .sda_o     (SDA_O),
    .sda_oe    (SDA_OE),
    .ptr       (ptr),
    .rd_data   (rd_data),
    .wr_stb    (wr_stb),
    .wr_data   (wr_data),
    .xact_done (xact_done)
  );

  assign rd_data = reg_read(ptr, sys_ctrl_r, therm_read_r, therm_meas_r,
                            derate_r);

  // plain read/write registers, restored by a hardware reset
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sys_ctrl_r   <= `CCT_RST_SYS_CTRL;  // [RULE1] [RULE2]
      therm_meas_r <= `CCT_RST_THERM_MEAS; // [RULE7]
      derate_r     <= `CCT_RST_DERATE;     // [RULE8]
    end else if (HW_RESET) begin
      sys_ctrl_r   <= `CCT_RST_SYS_CTRL;   // [RULE12]
      therm_meas_r <= `CCT_RST_THERM_MEAS; // [RULE12]
      derate_r     <= `CCT_RST_DERATE;     // [RULE12]
    end else if (wr_stb) begin
      if (hit(ptr, `CCT_OFS_SYS_CTRL))
        sys_ctrl_r <= wr_data;
      if (hit(ptr, `CCT_OFS_THERM_MEAS))
        therm_meas_r <= wr_data;
      if (hit(ptr, `CCT_OFS_DERATE))
        derate_r <= wr_data;
    end
  end

  // thermistor read register; a written trigger beats a finishing check
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      therm_read_r <= `CCT_RST_THERM_READ;
    end else if (HW_RESET) begin
      therm_read_r <= `CCT_RST_THERM_READ; // [RULE12]
    end else if (wr_stb && hit(ptr, `CCT_OFS_THERM_READ)) begin
      therm_read_r <= wr_data; // [RULE6]
    end else if (THERM_CHECK_DONE) begin
      therm_read_r[`CCT_TRIGGER_BIT] <= 1'b0; // [RULE6]
    end
  end

  // host-silence watchdog
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wd_cnt_r   <= 32'h0000_0000;
      wd_armed_r <= 1'b0;
      HW_RESET   <= 1'b0;
    end else begin
      HW_RESET <= 1'b0;
      if (sup_s_r && !sup_d_r) begin
        wd_cnt_r   <= 32'h0000_0000; // [RULE13]
        wd_armed_r <= 1'b1;
      end else if (xact_done || !sup_s_r) begin
        wd_armed_r <= 1'b0; // [RULE13]
      end else if (wd_armed_r && sys_ctrl_r[`CCT_WD_EN_BIT]) begin
        if (wd_cnt_r == WD_CYCLES - 1) begin
          HW_RESET   <= 1'b1; // [RULE3] [RULE12]
          wd_armed_r <= 1'b0;
        end else begin
          wd_cnt_r <= wd_cnt_r + 32'h0000_0001; // [RULE3]
        end
      end
    end
  end

  // one-second poll tick while on battery alone
  assign poll_due = (poll_cnt_r == POLL_CYCLES - 1);
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      poll_cnt_r <= 32'h0000_0000;
    end else if (sup_s_r || poll_due ||
                 !therm_read_r[`CCT_POLL_MODE_BIT]) begin
      poll_cnt_r <= 32'h0000_0000; // [RULE5]
    end else begin
      poll_cnt_r <= poll_cnt_r + 32'h0000_0001; // [RULE5]
    end
  end

  // check requests: one pulse per check, none while one is running
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      THERM_CHECK_REQ <= 1'b0;
      check_busy_r    <= 1'b0;
    end else begin
      THERM_CHECK_REQ <= 1'b0;
      if (THERM_CHECK_DONE) begin
        check_busy_r <= 1'b0;
      end else if (!check_busy_r && !THERM_CHECK_REQ &&
                   (therm_read_r[`CCT_TRIGGER_BIT] || poll_due)) begin
        THERM_CHECK_REQ <= 1'b1; // [RULE5] [RULE6]
        check_busy_r    <= 1'b1;
      end
    end
  end

  // registered control outputs
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      SYS_RAIL_SETPOINT <= 3'h0;
      CHARGE_ALLOW      <= 1'b0;
      THERM_MEASURE_EN  <= 1'b0;
      PG_N_O            <= 1'b0;
      PG_N_OE           <= 1'b0;
      BAT_REG_DROP_MV   <= 9'h000;
      CHG_SCALE_EIGHTHS <= `CCT_SCALE_FULL;
    end else begin
      SYS_RAIL_SETPOINT <=
        sys_ctrl_r[`CCT_SETPOINT_HI:`CCT_SETPOINT_LO]; // [RULE1]
      CHARGE_ALLOW <= !sys_ctrl_r[`CCT_CHG_INHIBIT_BIT] && !ce_s_r; // [RULE4]
      THERM_MEASURE_EN <= therm_meas_r[`CCT_MEAS_EN_BIT]; // [RULE7]
      PG_N_O <= 1'b0;
      if (PG_PIN_FUNCTION[`CCT_PG_FN_GPO_BIT])
        PG_N_OE <= !sys_ctrl_r[`CCT_PG_LEVEL_BIT]; // [RULE2] [RULE11]
      else
        PG_N_OE <= PG_ALT_PULL_LOW;
      BAT_REG_DROP_MV <= BATTERY_WARM ?
        9'(derate_r[`CCT_VDROP_HI:`CCT_VDROP_LO] * `CCT_VDROP_STEP_MV) :
        9'h000; // [RULE9]
      CHG_SCALE_EIGHTHS <= (DERATE_ACTIVE &&
                            derate_r[`CCT_ISCALE_HI:`CCT_ISCALE_LO] != 3'h0) ?
        4'(`CCT_SCALE_FULL - {1'b0, derate_r[`CCT_ISCALE_HI:`CCT_ISCALE_LO]}) :
        `CCT_SCALE_FULL; // [RULE10]
    end
  end
endmodule

// ### test/cct_regs_monitor.sv
// port checker for the charger register bank
`timescale 1ns/1ns
module cct_regs_monitor (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       CHARGE_EN_N,
  input wire logic [1:0] PG_PIN_FUNCTION,
  input wire logic       PG_ALT_PULL_LOW,
  input wire logic       BATTERY_WARM,
  input wire logic       DERATE_ACTIVE,
  input wire logic       SDA_O,
  input wire logic       PG_N_O,
  input wire logic       PG_N_OE,
  input wire logic [2:0] SYS_RAIL_SETPOINT,
  input wire logic       CHARGE_ALLOW,
  input wire logic       THERM_CHECK_REQ,
  input wire logic [8:0] BAT_REG_DROP_MV,
  input wire logic [3:0] CHG_SCALE_EIGHTHS,
  input wire logic       HW_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // check request and reset are single pulses
  AST_REQ_PULSE: assert property (
    THERM_CHECK_REQ |=> !THERM_CHECK_REQ)
    else $error("check request held too long");
  AST_HWRST_PULSE: assert property (
    HW_RESET |=> !HW_RESET) else $error("reset pulse held too long");
  // a reset brings the rail setpoint back to its default
  AST_HWRST_DEFAULT: assert property (
    HW_RESET |-> ##[1:3] SYS_RAIL_SETPOINT == 3'b010)
    else $error("setpoint not restored");
  // pin high disables charging
  AST_CHG_INHIBIT: assert property (
    CHARGE_EN_N [*5] |-> !CHARGE_ALLOW) else $error("charge while pin high");
  // not warm, no drop
  AST_DROP_COLD: assert property (
    !BATTERY_WARM [*4] |-> BAT_REG_DROP_MV == 9'h000)
    else $error("drop while not warm");
  AST_DROP_STEP: assert property (
    BAT_REG_DROP_MV <= 9'h15E && BAT_REG_DROP_MV % 50 == 0)
    else $error("drop off the 50 mV grid");
  AST_SCALE_FULL: assert property (
    !DERATE_ACTIVE [*4] |-> CHG_SCALE_EIGHTHS == 4'h8)
    else $error("scale cut while not derating");
  AST_SCALE_RANGE: assert property (
    CHG_SCALE_EIGHTHS inside {[4'h1:4'h8]}) else $error("scale out of range");
  // other pin functions follow the alternative pull request
  AST_PG_ALT: assert property (
    (!PG_PIN_FUNCTION[1] && $stable(PG_ALT_PULL_LOW)) [*4]
    |-> PG_N_OE == PG_ALT_PULL_LOW) else $error("pin ignores alt request");
  AST_OPEN_DRAIN: assert property (
    SDA_O == 1'b0 && PG_N_O == 1'b0) else $error("open drain drives high");
endmodule

bind cct_regs cct_regs_monitor i_cct_regs_monitor (.CLK, .RST_B,
  .CHARGE_EN_N, .PG_PIN_FUNCTION, .PG_ALT_PULL_LOW, .BATTERY_WARM,
  .DERATE_ACTIVE, .SDA_O, .PG_N_O, .PG_N_OE, .SYS_RAIL_SETPOINT,
  .CHARGE_ALLOW, .THERM_CHECK_REQ, .BAT_REG_DROP_MV, .CHG_SCALE_EIGHTHS,
  .HW_RESET);

// ### test/cct_i2c_host.sv
// i2c host controller model for the register bank
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_i2c_host (
  input  wire logic  CLK,
  input  wire logic  SDA_LINE,
  output logic       SCL,
  output logic       SDA_LOW,
  output logic       RD_STB,
  output logic [7:0] RD_DATA
);
  localparam int HALF = 8;
  // bus idle, both lines released
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
    RD_STB = 1'b0;
    RD_DATA = 8'h00;
  end
  // wait edges, then move just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask
  // data changes only with scl low, held past the fall
  task automatic bit_out(input logic b);
    SDA_LOW = !b;
    tick(HALF);
    SCL = 1'b1;
    tick(HALF);
    SCL = 1'b0;
    tick(2);
  endtask
  task automatic bit_in(output logic b);
    SDA_LOW = 1'b0;
    tick(HALF);
    SCL = 1'b1;
    tick(HALF / 2);
    b = SDA_LINE;
    tick(HALF / 2);
    SCL = 1'b0;
    tick(2);
  endtask
  // start or repeated start
  task automatic start();
    SDA_LOW = 1'b0;
    tick(HALF);
    SCL = 1'b1;
    tick(HALF);
    SDA_LOW = 1'b1;
    tick(HALF);
    SCL = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    SDA_LOW = 1'b1;
    tick(HALF);
    SCL = 1'b1;
    tick(HALF);
    SDA_LOW = 1'b0;
    tick(HALF);
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
  endtask
  task automatic write_reg(input logic [7:0] a, d);
    start();
    wbyte({`CCT_I2C_ADDR, 1'b0});
    wbyte(a);
    wbyte(d);
    stop();
  endtask
  // pointer write, repeated start, one byte, nack, stop
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    start();
    wbyte({`CCT_I2C_ADDR, 1'b0});
    wbyte(a);
    start();
    wbyte({`CCT_I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop();
    RD_DATA = d;
    RD_STB = 1'b1;
    tick(1);
    RD_STB = 1'b0;
  endtask
endmodule

// ### test/charger_control_thermal_regs_test.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ns
module charger_control_thermal_regs_test;
  logic       clk = 1'b0, rst_b, supply, ce_n, pg_alt, warm, derate;
  logic [1:0] pg_fn;
  logic       chk_done = 1'b0;
  wire        sda_line;
  logic       scl, sda_low, sda_oe, sda_o, pg_n_o, pg_n_oe, chg_allow;
  logic       meas_en, chk_req, hw_reset, rd_stb;
  logic [2:0] setpoint;
  logic [8:0] drop;
  logic [3:0] scale;
  logic [7:0] rd_data, e_q, v, d;
  logic [7:0] exp_q[$];
  int         errors = 0, samples_checked = 0, req_cnt = 0, hw_cnt = 0;
  int         n, c, seed_v;
`define CHK(nm, ex, got) \
  begin samples_checked++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

  always #25 clk = ~clk;
  // wired-and data line with pull-up
  assign sda_line = (sda_low | sda_oe) ? 1'b0 : 1'b1;

  cct_regs #(.WD_CYCLES(2000), .POLL_CYCLES(50)) i_cct_regs (
    .CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .INPUT_SUPPLY_PRESENT(supply), .CHARGE_EN_N(ce_n),
    .PG_PIN_FUNCTION(pg_fn), .PG_ALT_PULL_LOW(pg_alt),
    .BATTERY_WARM(warm), .DERATE_ACTIVE(derate),
    .THERM_CHECK_DONE(chk_done), .PG_N_O(pg_n_o), .PG_N_OE(pg_n_oe),
    .SYS_RAIL_SETPOINT(setpoint), .CHARGE_ALLOW(chg_allow),
    .THERM_MEASURE_EN(meas_en), .THERM_CHECK_REQ(chk_req),
    .BAT_REG_DROP_MV(drop), .CHG_SCALE_EIGHTHS(scale),
    .HW_RESET(hw_reset));
  cct_i2c_host i_cct_i2c_host (.CLK(clk), .SDA_LINE(sda_line), .SCL(scl),
    .SDA_LOW(sda_low), .RD_STB(rd_stb), .RD_DATA(rd_data));

  // thermistor check finishes one cycle after each request
  always @(posedge clk) chk_done <= #2 (chk_req === 1'b1);
  always @(posedge clk) begin
    if (chk_req === 1'b1) req_cnt++;
    if (hw_reset === 1'b1) hw_cnt++;
  end
  // read results against the oldest note
  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      e_q = exp_q.pop_front();
      `CHK("read data", e_q, rd_data)
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, dd);
    i_cct_i2c_host.write_reg(a, dd);
  endtask
  task automatic rd(input logic [7:0] a, ex, output logic [7:0] got);
    exp_q.push_back(ex);
    i_cct_i2c_host.read_reg(a, got);
    step(1);
  endtask
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    seed_v = $urandom(54);
    {rst_b, supply, ce_n, pg_alt, warm, derate, pg_fn} = 8'h00;
    repeat (3) @(posedge clk);
    #2 rst_b = 1'b1;
    step(6);
    // defaults and derived outputs
    `CHK("setpoint", 3'b010, setpoint)
    `CHK("scale", 4'h8, scale)
    `CHK("pg oe", 1'b0, pg_n_oe)
    rd(8'h37, 8'h40, v);
    rd(8'h40, 8'h02, v);
    rd(8'h58, 8'h00, v);
    rd(8'h61, 8'h34, v);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00, v);
    {warm, derate} = 2'b11;
    step(4);
    `CHK("scale", 4'h4, scale)
    `CHK("drop", 9'h096, drop)
    // every code of the setpoint and derating fields
    for (c = 0; c < 8; c++) begin
      wr(8'h37, {c[2:0], 5'h00});
      `CHK("setpoint", c[2:0], setpoint)
      `CHK("charge allow", 1'b1, chg_allow)
      wr(8'h61, {1'b0, c[2:0], 1'b0, c[2:0]});
      `CHK("drop", 9'h032 * c[2:0], drop)
      `CHK("scale", (c == 0) ? 4'h8 : 4'h8 - c[3:0], scale)
    end
    // random contents, all bits written back
    for (c = 0; c < 3; c++) begin
      d = $urandom;
      wr(8'h58, d);
      rd(8'h58, d, v);
      `CHK("measure en", d[2], meas_en)
      d = $urandom;
      wr(8'h37, d);
      rd(8'h37, d, v);
      `CHK("charge allow", !d[0], chg_allow)
    end
    wr(8'h37, 8'h40);
    ce_n = 1'b1;
    step(6);
    `CHK("charge pin", 1'b0, chg_allow)
    ce_n = 1'b0;
    // power-good pin in output mode, then alternative mode
    pg_fn = 2'b10;
    step(4);
    `CHK("pg low", 1'b1, pg_n_oe)
    wr(8'h37, 8'h50);
    `CHK("pg high z", 1'b0, pg_n_oe)
    pg_fn = 2'b01;
    pg_alt = 1'b1;
    step(6);
    `CHK("pg alt", 1'b1, pg_n_oe)
    pg_alt = 1'b0;
    // one-shot check clears itself
    req_cnt = 0;
    wr(8'h40, 8'h22);
    step(4);
    `CHK("one shot", 1, req_cnt)
    rd(8'h40, 8'h02, v);
    // periodic checks on battery alone
    wr(8'h40, 8'h82);
    req_cnt = 0;
    step(260);
    `CHK("polls", 1'b1, req_cnt >= 4 && req_cnt <= 6)
    wr(8'h40, 8'h02);
    // watchdog enabled by read-modify-write, no host traffic
    rd(8'h37, 8'h50, v);
    wr(8'h37, v | 8'h02);
    supply = 1'b1;
    for (n = 0; n < 2100 && hw_cnt == 0; n++) step(1);
    `CHK("wd fired", 1, hw_cnt)
    `CHK("wd time", 1'b1, n >= 1995 && n <= 2010)
    rd(8'h37, 8'h40, v);
    rd(8'h61, 8'h34, v);
    // a finished transaction disarms until next supply arrival
    wr(8'h37, 8'h42);
    supply = 1'b0;
    step(4);
    supply = 1'b1;
    step(4);
    wr(8'h37, 8'h42);
    step(2500);
    `CHK("wd disarmed", 1, hw_cnt)
    // enable bit clear: a fresh supply arrival never resets
    wr(8'h37, 8'h40);
    supply = 1'b0;
    step(4);
    supply = 1'b1;
    step(2100);
    `CHK("wd off", 1, hw_cnt)
    print_verdict();
  end
endmodule
